/* design/ebu_pkg.sv */
`default_nettype none
package ebu_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int ADDR_W  = 24;	// full address
	localparam int DATA_W  = 16;	// data port width
	localparam int SEG_W   = 8;	// upper segment lines
	localparam int SEG_LSB = 16;	// first segment bit
	localparam int LOW_W   = 16;	// address port width
	localparam int BYTE_W  = 8;	// low byte lane
	localparam int NUM_WIN = 5;	// default plus four
	localparam int WIN_W   = 3;	// window index
	localparam int RNG_W   = 12;	// range base width
	localparam int RNG_LSB = 12;	// range base lsb
	localparam int SIZE_W  = 4;	// range size code
	localparam int WAIT_W  = 4;	// wait state count

	// ----------------------------------------
	// fixed codes
	// ----------------------------------------
	localparam logic [WIN_W-1:0] WIN_DEF = 3'h0;	// default window
	localparam logic [WIN_W-1:0] WIN_1   = 3'h1;
	localparam logic [WIN_W-1:0] WIN_2   = 3'h2;
	localparam logic [WIN_W-1:0] WIN_3   = 3'h3;
	localparam logic [WIN_W-1:0] WIN_4   = 3'h4;
	localparam logic [1:0] LANE_NONE = 2'h3;	// oe_n per byte
	localparam logic [1:0] LANE_LOW  = 2'h2;
	localparam logic [1:0] LANE_BOTH = 2'h0;
	localparam logic [SEG_W-1:0] SEG_OE_16M  = 8'h00;
	localparam logic [SEG_W-1:0] SEG_OE_1M   = 8'hf0;
	localparam logic [SEG_W-1:0] SEG_OE_256K = 8'hfc;
	localparam logic [SEG_W-1:0] SEG_OE_64K  = 8'hff;
	localparam logic [WAIT_W-1:0] ALE_EXTRA = 4'h1;	// long ale
	localparam logic [WAIT_W-1:0] DLY_EXTRA = 4'h0;	// rw delay

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_OFF, MODE_DMX16, MODE_MUX16, MODE_MUX8, MODE_DMX8
	} bus_mode_t;
	typedef enum logic [1:0] {
		SPACE_16M, SPACE_1M, SPACE_256K, SPACE_64K
	} addr_space_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ALE, ST_DELAY, ST_STROBE, ST_RECOV, ST_HELD
	} state_t;
endpackage
`default_nettype wire

/* design/external_bus_unit.sv */
// Functional notes
// RULE1: single chip or four address/data modes
// RULE2: demux: address port, data port or low byte
// RULE3: mux: address then data on data port
// RULE4: wait, recovery, ale length, strobe delay programmable
// RULE5: four windows, range plus bus config each
// RULE6: window four beats three, two beats one
// RULE7: unmatched addresses use default configuration
// RULE8: five active low window selects
// RULE9: ready input stretches slow bus cycles
// RULE10: arbitration pins idle until enable set
// RULE11: master after reset, direction bit selects slave
// RULE12: space limit gives four, two, none segments
// RULE13: full space drives all eight segment lines
// RULE14: selects change one phase after ale, or with
// RULE15: per window ready polarity bit
// RULE16: device ends ready cycles at active level
// RULE17: granted bus floats outputs, blocks own accesses
`timescale 1ns/1ps
`default_nettype none
module external_bus_unit (
	input  wire logic                         clk,
	input  wire logic                         resetn,
	// cpu request side
	input  wire logic                         req_valid,
	output logic                              req_ready,
	input  wire logic [ebu_pkg::ADDR_W-1:0]   req_addr,
	input  wire logic                         req_write,
	input  wire logic [ebu_pkg::DATA_W-1:0]   req_wdata,
	output logic                              req_ack,
	output logic      [ebu_pkg::DATA_W-1:0]   req_rdata,
	// window configuration, index 0 is default
	input  wire ebu_pkg::bus_mode_t           win_mode [ebu_pkg::NUM_WIN],
	input  wire logic [ebu_pkg::WAIT_W-1:0]   win_wait [ebu_pkg::NUM_WIN],
	input  wire logic [ebu_pkg::NUM_WIN-1:0]  win_tristate,
	input  wire logic [ebu_pkg::NUM_WIN-1:0]  win_ale_long,
	input  wire logic [ebu_pkg::NUM_WIN-1:0]  win_rw_delay,
	input  wire logic [ebu_pkg::NUM_WIN-1:0]  win_ready_en,
	input  wire logic [ebu_pkg::NUM_WIN-1:0]  ready_polarity_bit,
	input  wire logic [4:1]                   range_en,
	input  wire logic [ebu_pkg::RNG_W-1:0]    range_base [1:4],
	input  wire logic [ebu_pkg::SIZE_W-1:0]   range_size [1:4],
	input  wire ebu_pkg::addr_space_t         addr_space,
	input  wire logic                         select_timing_config_bit,
	input  wire logic                         arbitration_enable_flag,
	input  wire logic                         ack_pin_direction_bit,
	// external pins
	output logic      [ebu_pkg::LOW_W-1:0]    address_port_o,
	output logic      [ebu_pkg::SEG_W-1:0]    seg_addr_o,
	output logic      [ebu_pkg::SEG_W-1:0]    seg_oe_n,
	input  wire logic [ebu_pkg::DATA_W-1:0]   data_port_i,
	output logic      [ebu_pkg::DATA_W-1:0]   data_port_o,
	output logic      [1:0]                   data_port_oe_n,
	output logic                              ale_o,
	output logic                              rd_n_o,
	output logic                              wr_n_o,
	output logic      [ebu_pkg::NUM_WIN-1:0]  window_select_n_o,
	output logic                              bus_oe_n,
	input  wire logic                         ready_i,
	input  wire logic                         hold_n_i,
	output logic                              bus_need_n_o,
	output logic                              bus_need_oe_n,
	input  wire logic                         bus_grant_ack_i,
	output logic                              bus_grant_ack_o,
	output logic                              bus_grant_ack_oe_n
);
	// ----------------------------------------
	// state record
	// ----------------------------------------
	typedef struct packed {
		ebu_pkg::state_t                st;	// bus sequencer
		logic [ebu_pkg::WAIT_W-1:0]     cnt;	// phase counter
		logic [ebu_pkg::WIN_W-1:0]      win;	// window of cycle
		logic [ebu_pkg::ADDR_W-1:0]     addr;	// latched address
		logic                           we;	// write cycle
		logic [ebu_pkg::DATA_W-1:0]     wdat;	// write data
		logic [ebu_pkg::DATA_W-1:0]     rdat;	// read data
		logic                           ack;	// done pulse
		logic                           ale;
		logic                           rd_n;
		logic                           wr_n;
		logic [ebu_pkg::NUM_WIN-1:0]    cs_n;	// window selects
		logic                           cs_pend;	// late select
		logic [ebu_pkg::DATA_W-1:0]     dout;	// data port drive
		logic [1:0]                     doe_n;	// lane enables
		logic                           rdy1, rdy2;	// ready sync
		logic                           hld1, hld2;	// hold sync
		logic                           gnt1, gnt2;	// grant sync
		logic                           arb_on;	// sticky enable
		logic                           granted;	// bus given away
	} ebu_state_t;

	ebu_state_t s_r;	// registered state
	ebu_state_t s_nxt;	// next state
	logic [1:0] rst_sync_r;	// reset release chain
	logic       rst_n;	// synchronised reset

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rst_sync_r <= '0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// one-hot active low select for a window
	function automatic logic [ebu_pkg::NUM_WIN-1:0] cs_vec(
		input logic [ebu_pkg::WIN_W-1:0] w
	);
		cs_vec = '1;
		cs_vec[w] = 1'b0;	// [RULE8]
	endfunction

	function automatic logic is_mux(input ebu_pkg::bus_mode_t m);
		return m == ebu_pkg::MODE_MUX16 || m == ebu_pkg::MODE_MUX8;
	endfunction

	function automatic logic is_byte(input ebu_pkg::bus_mode_t m);
		return m == ebu_pkg::MODE_MUX8 || m == ebu_pkg::MODE_DMX8;
	endfunction

	logic [4:1]                win_hit;	// per window match
	logic [ebu_pkg::WIN_W-1:0] win_sel;	// prioritised window

	window_decoder u_dec (
		.addr     (req_addr),
		.win_en   (range_en),
		.rng_base (range_base),
		.rng_size (range_size),
		.hit      (win_hit),
		.win_sel  (win_sel)
	);

	// ----------------------------------------
	// arbitration terms
	// ----------------------------------------
	logic slave;	// ack pin is an input
	logic hold_take;	// master gives bus away
	logic may_own;	// own cycles allowed
	logic floating;	// outputs released
	logic rdy_act;	// ready at active level
	ebu_pkg::bus_mode_t cur_mode;	// mode of running cycle

	assign slave     = ack_pin_direction_bit;	// [RULE11]
	assign hold_take = s_r.arb_on && !slave && !s_r.hld2;	// [RULE10]
	assign may_own   = !s_r.arb_on || (slave ? !s_r.gnt2 : s_r.hld2);
	assign floating  = s_r.st == ebu_pkg::ST_HELD
		|| (s_r.arb_on && slave && s_r.gnt2
		&& s_r.st == ebu_pkg::ST_IDLE);	// [RULE17]
	assign rdy_act   = s_r.rdy2 == ready_polarity_bit[s_r.win];	// [RULE15]
	assign cur_mode  = win_mode[s_r.win];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// one pass; go_strobe shares the strobe start of two states
	always_comb begin
		logic go_strobe;
		go_strobe = 1'b0;
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.rdy1 = ready_i;
		s_nxt.rdy2 = s_r.rdy1;
		s_nxt.hld1 = hold_n_i;
		s_nxt.hld2 = s_r.hld1;
		s_nxt.gnt1 = bus_grant_ack_i;
		s_nxt.gnt2 = s_r.gnt1;
		// once set, arbitration stays on until reset
		if (arbitration_enable_flag)
			s_nxt.arb_on = 1'b1;	// [RULE10]
		// late select lands one phase after ale rose
		if (s_r.cs_pend) begin
			s_nxt.cs_n = cs_vec(s_r.win);	// [RULE14]
			s_nxt.cs_pend = 1'b0;
		end
		unique case (s_r.st)
			ebu_pkg::ST_IDLE: begin
				if (hold_take) begin
					s_nxt.st = ebu_pkg::ST_HELD;	// [RULE17]
					s_nxt.granted = 1'b1;
				end else if (req_valid && may_own) begin
					s_nxt.addr = req_addr;
					s_nxt.we   = req_write;
					s_nxt.wdat = req_wdata;
					s_nxt.win  = win_sel;	// [RULE5]
					if (win_mode[win_sel] == ebu_pkg::MODE_OFF) begin
						// single chip: no external cycle at all
						s_nxt.ack  = 1'b1;	// [RULE1]
						s_nxt.rdat = '0;
					end else begin
						s_nxt.st   = ebu_pkg::ST_ALE;
						s_nxt.ale  = 1'b1;
						s_nxt.cnt  = win_ale_long[win_sel]
							? ebu_pkg::ALE_EXTRA : '0;	// [RULE4]
						s_nxt.dout = req_addr[ebu_pkg::LOW_W-1:0];
						// mux: address goes out on data port
						s_nxt.doe_n = is_mux(win_mode[win_sel])
							? ebu_pkg::LANE_BOTH
							: ebu_pkg::LANE_NONE;	// [RULE3]
						if (select_timing_config_bit)
							s_nxt.cs_n = cs_vec(win_sel);	// [RULE14]
						else
							s_nxt.cs_pend = 1'b1;	// [RULE14]
					end
				end
			end
			ebu_pkg::ST_ALE: begin
				if (s_r.cnt != '0) begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end else begin
					s_nxt.ale = 1'b0;
					s_nxt.doe_n = ebu_pkg::LANE_NONE;
					if (win_rw_delay[s_r.win]) begin
						s_nxt.st  = ebu_pkg::ST_DELAY;	// [RULE4]
						s_nxt.cnt = ebu_pkg::DLY_EXTRA;
					end else begin
						go_strobe = 1'b1;
					end
				end
			end
			ebu_pkg::ST_DELAY: begin
				if (s_r.cnt != '0)
					s_nxt.cnt = s_r.cnt - 1'b1;
				else
					go_strobe = 1'b1;
			end
			ebu_pkg::ST_STROBE: begin
				if (s_r.cnt != '0) begin
					s_nxt.cnt = s_r.cnt - 1'b1;	// [RULE4]
				end else if (win_ready_en[s_r.win] && !rdy_act) begin
					// slow device holds the cycle open
					s_nxt.st = ebu_pkg::ST_STROBE;	// [RULE9] [RULE16]
				end else begin
					s_nxt.rdat = s_r.we ? '0 : data_port_i;	// writes give zero
					if (is_byte(cur_mode))
						s_nxt.rdat[ebu_pkg::DATA_W-1:ebu_pkg::BYTE_W]
							= '0;	// [RULE2]
					s_nxt.rd_n = 1'b1;
					s_nxt.wr_n = 1'b1;
					s_nxt.cs_n = '1;
					s_nxt.cs_pend = 1'b0;
					s_nxt.doe_n = ebu_pkg::LANE_NONE;
					s_nxt.ack = 1'b1;
					s_nxt.st = win_tristate[s_r.win]
						? ebu_pkg::ST_RECOV
						: ebu_pkg::ST_IDLE;	// [RULE4]
				end
			end
			ebu_pkg::ST_RECOV: begin
				// one idle cycle lets the slow device let go
				s_nxt.st = ebu_pkg::ST_IDLE;	// [RULE4]
			end
			ebu_pkg::ST_HELD: begin
				if (s_r.hld2) begin
					s_nxt.st = ebu_pkg::ST_IDLE;
					s_nxt.granted = 1'b0;
				end
			end
		endcase
		// strobe start: write data lanes follow the mode width
		if (go_strobe) begin
			s_nxt.st   = ebu_pkg::ST_STROBE;
			s_nxt.cnt  = win_wait[s_r.win];	// [RULE4]
			s_nxt.rd_n = s_r.we;
			s_nxt.wr_n = !s_r.we;
			if (s_r.we) begin
				s_nxt.dout  = s_r.wdat;
				s_nxt.doe_n = is_byte(cur_mode)
					? ebu_pkg::LANE_LOW
					: ebu_pkg::LANE_BOTH;	// [RULE2] [RULE3]
			end
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s_r <= '{st: ebu_pkg::ST_IDLE, rd_n: 1'b1, wr_n: 1'b1,
				cs_n: '1, doe_n: ebu_pkg::LANE_NONE, rdy1: 1'b0,
				rdy2: 1'b0, hld1: 1'b1, hld2: 1'b1, gnt1: 1'b1,
				gnt2: 1'b1, default: '0};
		else
			s_r <= s_nxt;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// segment lines enabled per address space limit
	always_comb begin
		unique case (addr_space)
			ebu_pkg::SPACE_16M:  seg_oe_n = ebu_pkg::SEG_OE_16M;	// [RULE13]
			ebu_pkg::SPACE_1M:   seg_oe_n = ebu_pkg::SEG_OE_1M;	// [RULE12]
			ebu_pkg::SPACE_256K: seg_oe_n = ebu_pkg::SEG_OE_256K;
			ebu_pkg::SPACE_64K:  seg_oe_n = ebu_pkg::SEG_OE_64K;
		endcase
		if (floating)
			seg_oe_n = '1;
	end

	assign req_ready = s_r.st == ebu_pkg::ST_IDLE && may_own && !hold_take;
	assign req_ack           = s_r.ack;
	assign req_rdata         = s_r.rdat;
	assign address_port_o    = s_r.addr[ebu_pkg::LOW_W-1:0];	// [RULE2]
	assign seg_addr_o        = s_r.addr[ebu_pkg::SEG_LSB +: ebu_pkg::SEG_W];
	assign data_port_o       = s_r.dout;
	assign data_port_oe_n    = floating ? ebu_pkg::LANE_NONE : s_r.doe_n;
	assign ale_o             = s_r.ale;
	assign rd_n_o            = s_r.rd_n;
	assign wr_n_o            = s_r.wr_n;
	assign window_select_n_o = s_r.cs_n;
	assign bus_oe_n          = floating;	// [RULE17]
	// master asks back while held off; slave asks while ungranted
	assign bus_need_n_o = !(s_r.arb_on && req_valid
		&& (slave ? s_r.gnt2 : s_r.granted));
	assign bus_need_oe_n      = !s_r.arb_on;	// [RULE10]
	assign bus_grant_ack_o    = !s_r.granted;
	assign bus_grant_ack_oe_n = !(s_r.arb_on && !slave);	// [RULE11]

	// ----------------------------------------
	// checks
	// ----------------------------------------
	prio_high_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE6]
		win_hit[4] |-> win_sel == ebu_pkg::WIN_4)
		else $error("window four lost priority");
	prio_low_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE6]
		(win_hit[2] && !win_hit[3] && !win_hit[4])
		|-> win_sel == ebu_pkg::WIN_2)
		else $error("window two lost priority");
	default_win_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE7]
		win_hit == '0 |-> win_sel == ebu_pkg::WIN_DEF)
		else $error("unmatched address not default");
	one_select_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE8]
		$onehot0(~window_select_n_o))
		else $error("more than one select active");
	cs_early_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE14]
		($rose(ale_o) && $past(select_timing_config_bit))
		|-> window_select_n_o != '1)
		else $error("select late with early timing");
	cs_late_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE14]
		($rose(ale_o) && !$past(select_timing_config_bit))
		|-> window_select_n_o == '1 ##1 window_select_n_o != '1)
		else $error("select not one phase late");
	wait_count_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE4]
		(s_r.st == ebu_pkg::ST_STROBE && s_r.cnt != '0)
		|=> s_r.st == ebu_pkg::ST_STROBE && !(rd_n_o && wr_n_o))
		else $error("strobe ended during wait states");
	ready_hold_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE9]
		(s_r.st == ebu_pkg::ST_STROBE && s_r.cnt == '0
		&& win_ready_en[s_r.win] && !rdy_act)
		|=> !req_ack && !(rd_n_o && wr_n_o))
		else $error("cycle ended without ready");
	mux_read_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE3]
		($fell(ale_o) && is_mux(cur_mode) && !s_r.we)
		|-> data_port_oe_n == ebu_pkg::LANE_NONE)
		else $error("mux read still drives data port");
	seg_limit_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE12]
		addr_space == ebu_pkg::SPACE_64K |-> seg_oe_n == '1)
		else $error("segment lines driven in 64k space");
	held_float_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE17]
		s_r.st == ebu_pkg::ST_HELD
		|-> bus_oe_n && data_port_oe_n == ebu_pkg::LANE_NONE && !req_ready)
		else $error("outputs driven while bus granted");
	arb_idle_a: assert property (@(posedge clk) disable iff (!rst_n)	// [RULE10]
		!s_r.arb_on |-> bus_grant_ack_oe_n && bus_need_oe_n
		&& s_r.st != ebu_pkg::ST_HELD)
		else $error("arbitration pins used before enable");
endmodule
`default_nettype wire

/* design/window_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module window_decoder (
	input  wire logic [ebu_pkg::ADDR_W-1:0] addr,
	input  wire logic [4:1]                 win_en,
	input  wire logic [ebu_pkg::RNG_W-1:0]  rng_base [1:4],
	input  wire logic [ebu_pkg::SIZE_W-1:0] rng_size [1:4],
	output logic      [4:1]                 hit,
	output logic      [ebu_pkg::WIN_W-1:0]  win_sel
);
	// ----------------------------------------
	// range compare
	// ----------------------------------------
	// size code clears that many low base bits from the compare
	function automatic logic range_hit(
		input logic [ebu_pkg::RNG_W-1:0]  a,
		input logic [ebu_pkg::RNG_W-1:0]  b,
		input logic [ebu_pkg::SIZE_W-1:0] sz
	);
		logic [ebu_pkg::RNG_W-1:0] m;
		m = '1;
		m = m << sz;
		return ((a ^ b) & m) == '0;
	endfunction

	// one comparator per window
	genvar gi;
	generate
		for (gi = 1; gi <= 4; gi++) begin : g_win
			assign hit[gi] = win_en[gi] & range_hit(
				addr[ebu_pkg::RNG_LSB +: ebu_pkg::RNG_W],
				rng_base[gi], rng_size[gi]);
		end
	endgenerate

	// higher window wins an overlap, none hit means default
	always_comb begin
		if (hit[4])
			win_sel = ebu_pkg::WIN_4;	// [RULE6]
		else if (hit[3])
			win_sel = ebu_pkg::WIN_3;
		else if (hit[2])
			win_sel = ebu_pkg::WIN_2;	// [RULE6]
		else if (hit[1])
			win_sel = ebu_pkg::WIN_1;
		else
			win_sel = ebu_pkg::WIN_DEF;	// [RULE7]
	end
endmodule
`default_nettype wire

/* sim/ext_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] address_port_o,
	input  wire logic        ale_o,
	input  wire logic        rd_n_o,
	input  wire logic        wr_n_o,
	input  wire logic [15:0] data_port_o,
	input  wire logic        rdy_pol,
	input  wire logic [3:0]  rdy_dly,
	output logic      [15:0] data_port_i,
	output logic             ready_i
);
	// ----
	// storage
	// ----
	logic [15:0] mem [256];	// aliases above 256 words
	logic [7:0]  addr_r = 8'h00;	// address taken during ale
	logic [15:0] last_r = 16'h0000;	// last value put on the port
	logic [3:0]  cnt_r = 4'h0;	// strobe cycles so far

	// latch address, store writes, time the strobe
	always @(posedge clk) begin
		if (ale_o)
			addr_r <= address_port_o[7:0];
		if (!wr_n_o)
			mem[addr_r] <= data_port_o;
		if (!rd_n_o)
			last_r <= data_port_i;
		if ((!rd_n_o || !wr_n_o) && cnt_r != 4'hf)
			cnt_r <= cnt_r + 4'h1;
		else if (rd_n_o && wr_n_o)
			cnt_r <= 4'h0;
	end

	// released port shows the inverse, never a stale value
	assign data_port_i = !rd_n_o ? mem[addr_r] : ~last_r;
	// slow device: ready only after rdy_dly strobe cycles
	assign ready_i = ((!rd_n_o || !wr_n_o) && cnt_r >= rdy_dly)
		? rdy_pol : !rdy_pol;
endmodule
`default_nettype wire

/* sim/test_external_bus_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module test_external_bus_unit;
	// ----
	// signals
	// ----
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [23:0] req_addr = '0;
	logic [15:0] req_wdata = '0;
	ebu_pkg::bus_mode_t win_mode [ebu_pkg::NUM_WIN];
	logic [3:0] win_wait [ebu_pkg::NUM_WIN];
	logic [4:0] win_tristate = '0, win_ale_long = '0, win_rw_delay = '0;
	logic [4:0] win_ready_en = '0, ready_polarity_bit = '0;
	logic [4:1] range_en = '0;
	logic [11:0] range_base [1:4];
	logic [3:0] range_size [1:4];
	ebu_pkg::addr_space_t addr_space = ebu_pkg::SPACE_16M;
	logic select_timing_config_bit = 1'b0, arbitration_enable_flag = 1'b0;
	logic ack_pin_direction_bit = 1'b0, hold_n_i = 1'b1;
	logic bus_grant_ack_i = 1'b1, rdy_pol = 1'b1;
	logic [3:0] rdy_dly = 4'h0;
	logic req_ready, req_ack, ale_o, rd_n_o, wr_n_o, bus_oe_n, ready_i;
	logic bus_need_n_o, bus_need_oe_n, bus_grant_ack_o, bus_grant_ack_oe_n;
	logic [15:0] req_rdata, address_port_o, data_port_i, data_port_o, dp_ale;
	logic [15:0] ap_ale;	// address port while ale is high
	logic [7:0] seg_addr_o, seg_oe_n;
	logic [1:0] data_port_oe_n, oe_st, lane;
	logic [4:0] window_select_n_o, sel_all, sel_ale;
	logic [7:0] seg_tbl [4] = '{ebu_pkg::SEG_OE_16M, ebu_pkg::SEG_OE_1M,
		ebu_pkg::SEG_OE_256K, ebu_pkg::SEG_OE_64K};
	logic [15:0] exp_q [$];	// expected read data, oldest first
	int errors = 0, n_compared = 0, cyc = 0, lat = 0;

	external_bus_unit dut (
		.clk, .resetn, .req_valid, .req_ready, .req_addr, .req_write,
		.req_wdata, .req_ack, .req_rdata, .win_mode, .win_wait,
		.win_tristate, .win_ale_long, .win_rw_delay, .win_ready_en,
		.ready_polarity_bit, .range_en, .range_base, .range_size,
		.addr_space, .select_timing_config_bit, .arbitration_enable_flag,
		.ack_pin_direction_bit, .address_port_o, .seg_addr_o, .seg_oe_n,
		.data_port_i, .data_port_o, .data_port_oe_n, .ale_o, .rd_n_o,
		.wr_n_o, .window_select_n_o, .bus_oe_n, .ready_i, .hold_n_i,
		.bus_need_n_o, .bus_need_oe_n, .bus_grant_ack_i, .bus_grant_ack_o,
		.bus_grant_ack_oe_n
	);
	ext_mem_model mem_model (
		.clk, .address_port_o, .ale_o, .rd_n_o, .wr_n_o, .data_port_o,
		.rdy_pol, .rdy_dly, .data_port_i, .ready_i
	);

	// ----
	// clock, hang guard, ack watcher
	// ----
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			errors++;
			results();
		end
	end
	// an ack with nothing pending is a fault of its own
	always @(negedge clk) begin
		if (req_ack === 1'b1) begin
			if (exp_q.size() == 0)
				check(24'h00_0001, 24'h00_0000);
			else
				check(req_rdata, exp_q.pop_front());
		end
	end

	// ----
	// tasks
	// ----
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one cpu access; lat counts edges from take to ack
	task automatic access(input logic [23:0] a, input logic wr,
		input logic [15:0] d, input logic [15:0] e);
		bit got_ale;
		exp_q.push_back(e);
		req_addr = a;
		req_write = wr;
		req_wdata = d;
		req_valid = 1'b1;
		for (lat = 0; req_ready !== 1'b1 && lat < 200; lat++)
			@(negedge clk);
		@(posedge clk);
		sel_all = 5'h1f;
		got_ale = 1'b0;
		oe_st = ebu_pkg::LANE_NONE;
		for (lat = 0; lat < 200; lat++) begin
			@(negedge clk);
			req_valid = 1'b0;
			sel_all &= window_select_n_o;
			if (ale_o && !got_ale) begin
				got_ale = 1'b1;
				sel_ale = window_select_n_o;
				dp_ale = data_port_o;
				ap_ale = address_port_o;
			end
			if (!rd_n_o || !wr_n_o)
				oe_st = data_port_oe_n;
			if (req_ack === 1'b1)
				break;
		end
		if (lat == 200)
			errors++;
	endtask

	// ----
	// main sequence
	// ----
	initial begin
		int w, l, dl, m;
		logic [23:0] a;
		logic [15:0] d, msk;
		logic [23:0] adr [5];
		int win [5];
		w = $urandom(23409);
		foreach (win_mode[i]) begin
			win_mode[i] = ebu_pkg::MODE_DMX16;
			win_wait[i] = 4'h0;
		end
		range_base = '{12'h100, 12'h101, 12'h200, 12'h201};
		range_size = '{4'h4, 4'h0, 4'h4, 4'h0};
		repeat (10) @(negedge clk);
		check({ale_o, rd_n_o, wr_n_o, window_select_n_o}, 8'h7f);
		check({bus_grant_ack_oe_n, bus_need_oe_n}, 2'h3);
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		// every external mode, random timing, both select timings
		for (m = 1; m <= 4; m++) begin
			win_mode[0] = ebu_pkg::bus_mode_t'(m);
			w = $urandom_range(3);
			l = $urandom_range(1);
			dl = $urandom_range(1);
			win_wait[0] = 4'(w);
			win_ale_long[0] = l[0];
			win_rw_delay[0] = dl[0];
			win_tristate[0] = m[0];
			select_timing_config_bit = m[1];
			a = {8'h30, 16'($urandom)};
			d = 16'($urandom);
			msk = (m >= 3) ? 16'h00ff : 16'hffff;
			lane = (m >= 3) ? ebu_pkg::LANE_LOW : ebu_pkg::LANE_BOTH;
			access(a, 1'b1, d, 16'h0000);
			check(lat, 2 + l + dl + w);
			check(sel_all, 5'h1e);
			check(sel_ale, m[1] ? 5'h1e : 5'h1f);
			check(oe_st, lane);
			check(ap_ale, a[15:0]);
			if (m == 2 || m == 3)
				check(dp_ale & msk, a[15:0] & msk);
			access(a, 1'b0, 16'h0000, d & msk);
			check(oe_st, ebu_pkg::LANE_NONE);
		end
		// single chip: no external cycle at all
		win_mode[0] = ebu_pkg::MODE_OFF;
		access(24'h30_0010, 1'b0, 16'h0000, 16'h0000);
		check(sel_all, 5'h1f);
		check(lat < 2, 1'b1);
		// overlapping windows, each with its own wait count
		win_mode[0] = ebu_pkg::MODE_DMX16;
		foreach (win_wait[i])
			win_wait[i] = 4'(i);
		win_ale_long = '0;
		win_rw_delay = '0;
		range_en = 4'hf;
		adr = '{24'h10_1234, 24'h10_3234, 24'h20_1234, 24'h20_3234,
			24'h30_0234};
		win = '{2, 1, 4, 3, 0};
		for (int i = 0; i < 5; i++) begin
			d = 16'($urandom);
			access(adr[i], 1'b1, d, 16'h0000);
			check(sel_all, 5'h1f ^ (5'h01 << win[i]));
			check(lat, win[i] + 2);
			check(seg_addr_o, adr[i][23:16]);
			access(adr[i], 1'b0, 16'h0000, d);
		end
		// segment line enables per space limit
		for (int s = 0; s < 4; s++) begin
			addr_space = ebu_pkg::addr_space_t'(s);
			@(negedge clk);
			check(seg_oe_n, seg_tbl[s]);
		end
		addr_space = ebu_pkg::SPACE_16M;
		// slow device stretches the strobe, both ready levels
		win_ready_en[1] = 1'b1;
		rdy_dly = 4'h4;
		for (int p = 0; p < 2; p++) begin
			ready_polarity_bit[1] = p[0];
			rdy_pol = p[0];
			d = 16'($urandom);
			access(24'h10_3040, 1'b1, d, 16'h0000);
			check(lat > 5, 1'b1);
			access(24'h10_3040, 1'b0, 16'h0000, d);
		end
		// hold ignored until arbitration is enabled
		hold_n_i = 1'b0;
		repeat (6) @(negedge clk);
		check(bus_grant_ack_oe_n, 1'b1);
		access(24'h30_0100, 1'b1, 16'h5a5a, 16'h0000);
		check(lat, 2);
		arbitration_enable_flag = 1'b1;
		repeat (6) @(negedge clk);
		check({bus_grant_ack_o, bus_grant_ack_oe_n, bus_oe_n, req_ready},
			4'h2);
		req_addr = 24'h30_0100;
		req_write = 1'b0;
		req_valid = 1'b1;
		repeat (4) @(negedge clk);
		check({bus_need_n_o, bus_need_oe_n, req_ready}, 3'h0);
		hold_n_i = 1'b1;
		access(24'h30_0100, 1'b0, 16'h0000, 16'h5a5a);
		// slave role: pins float until granted
		ack_pin_direction_bit = 1'b1;
		repeat (6) @(negedge clk);
		check({bus_grant_ack_oe_n, bus_oe_n}, 2'h3);
		bus_grant_ack_i = 1'b0;
		repeat (4) @(negedge clk);
		access(24'h30_0100, 1'b0, 16'h0000, 16'h5a5a);
		check(bus_oe_n, 1'b0);
		results();
	end
endmodule
`default_nettype wire
